/* shared/dpf_defines.vh */
`ifndef DPF_DEFINES_VH
`define DPF_DEFINES_VH

// register indices; byte address is four times the index
`define DPF_IDX_DATA_IF 8'h02
`define DPF_IDX_FILT_MODE2 8'h03
`define DPF_IDX_INT_STATUS 8'h04
`define DPF_IDX_INT_MASK 8'h05
`define DPF_ADDR_LSB 2
`define DPF_IDX_W 8

// data interface control fields
`define DPF_B_FORMAT 7
`define DPF_B_SINGLE_PORT_INTERLEAVE 6
`define DPF_B_DRIVE 5
`define DPF_B_LOOP_EN 4
`define DPF_B_DIR 3
`define DPF_B_LOCKED 2
`define DPF_B_SLIPPED 1
`define DPF_B_JITTER 0
`define DPF_DATA_IF_WMASK 8'hF8

// filter mode control two fields
`define DPF_B_CHANNEL 7
`define DPF_B_REAL_OR_IMAG_SELECT 6
`define DPF_B_HILBERT 5
`define DPF_B_X8HP 4
`define DPF_B_X4HP 3
`define DPF_B_X2HP 2
`define DPF_FILT_WMASK 8'hFC

// interrupt status / mask fields
`define DPF_EV_LOCK 0
`define DPF_EV_SLIP 1
`define DPF_EV_JITTER 2
`define DPF_EV_W 3

`define DPF_RESET_8 8'h00
`define DPF_RESET_EV 3'h0

// ahb
`define DPF_HTRANS_NONSEQ 2'h2
`define DPF_HTRANS_SEQ 2'h3
`define DPF_HRESP_OKAY 1'h0

// data clock out: half period in mclk cycles, 200 ns at 50 ns per cycle
`define DPF_DCLK_HALF_NS 200
`define DPF_MCLK_NS 50
`define DPF_DCLK_HALF_CYC 8'h04

// loop monitor
`define DPF_PER_W 8
`define DPF_LOCK_EDGES 4'h4
`define DPF_SMP_W 12

`endif

/* core/dpf_sync2.v */
`timescale 1ns/1ps
module dpf_sync2 #(
  parameter W = 1
) (
  // clock and reset
  input wire clk,
  input wire rst,
  // data
  input wire [W-1:0] d,
  output reg [W-1:0] q
);

  reg [W-1:0] meta_reg;

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_reg <= {W{1'b0}};
      q <= {W{1'b0}};
    end else begin
      meta_reg <= d;
      q <= meta_reg;
    end
  end

endmodule

/* core/dpf_loop_mon.v */
`timescale 1ns/1ps
`include "dpf_defines.vh"
module dpf_loop_mon (
  // clock and reset
  input wire clk,
  input wire rst,
  // control
  input wire enable,
  input wire clk_edge,
  // status
  output reg locked_reg,
  output reg slipped_reg,
  output reg jitter_reg,
  output reg [`DPF_EV_W-1:0] event_reg
);

  reg [`DPF_PER_W-1:0] count_reg;
  reg [`DPF_PER_W-1:0] last_reg;
  reg [3:0] streak_reg;
  reg have_last_reg;
  wire [`DPF_PER_W-1:0] diff;
  wire same;
  wire near;

  assign diff = (count_reg > last_reg) ? (count_reg - last_reg) : (last_reg - count_reg);
  assign same = (diff == {`DPF_PER_W{1'b0}});
  assign near = (diff == {{(`DPF_PER_W-1){1'b0}}, 1'b1});

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      count_reg <= {`DPF_PER_W{1'b0}};
      last_reg <= {`DPF_PER_W{1'b0}};
      streak_reg <= 4'h0;
      have_last_reg <= 1'b0;
      locked_reg <= 1'b0;
      slipped_reg <= 1'b0;
      jitter_reg <= 1'b0;
      event_reg <= `DPF_RESET_EV;
    end else begin
      event_reg <= `DPF_RESET_EV;
      if (!enable) begin
        // lock history survives a disable; period tracking restarts
        count_reg <= {`DPF_PER_W{1'b0}};
        have_last_reg <= 1'b0;
        streak_reg <= 4'h0;
      end else if (clk_edge) begin
        count_reg <= {{(`DPF_PER_W-1){1'b0}}, 1'b1};
        last_reg <= count_reg;
        have_last_reg <= 1'b1;
        if (have_last_reg) begin
          if (!locked_reg) begin
            if (same || near) begin
              streak_reg <= streak_reg + 4'h1;
              if (streak_reg + 4'h1 >= `DPF_LOCK_EDGES) begin
                locked_reg <= 1'b1; // R08 R09
                event_reg[`DPF_EV_LOCK] <= 1'b1;
              end
            end else begin
              streak_reg <= 4'h0;
            end
          end else if (!same && !near) begin
            slipped_reg <= 1'b1; // R10
            event_reg[`DPF_EV_SLIP] <= 1'b1;
          end else if (near) begin
            jitter_reg <= 1'b1; // R11
            event_reg[`DPF_EV_JITTER] <= 1'b1;
          end
        end
      end else if (count_reg != {`DPF_PER_W{1'b1}}) begin
        count_reg <= count_reg + {{(`DPF_PER_W-1){1'b0}}, 1'b1};
      end
    end
  end

endmodule

/* core/dpf_top.v */
// How it works
// [R01] format bit set: samples are unsigned binary
// [R02] format bit clear: samples are two's complement
// [R03] dual port I/Q, or interleaved on port 1
// [R04] drive bit picks 12mA or 24mA drive
// [R05] loop enable bit runs the data clock loop; the code runs it only while the pin is an input
// [R06] direction clear: data clock pin is input
// [R07] direction set: device drives data clock out; the code keeps the pin an input while the external lock control is on
// [R08] lock status reads zero before first lock
// [R09] lock status stays set once achieved
// [R10] slip status set after relock phase move
// [R11] jitter status set on small cycle jitter
// [R12] channel bit routes I or Q to converter; the code honours it only outside sideband mode
// [R13] sideband mode: real or imaginary output select
// [R14] sideband mode: Hilbert stage enable bit
// [R15] bits 4,3 pick x8/x4 high-pass response
// [R16] bit 2 picks x2 high-pass response
// [R17] all writable fields reset to zero
//
// Register access over AHB-Lite was chosen for this implementation.
`timescale 1ns/1ps
`include "dpf_defines.vh"
module dpf_top (
  // clock and reset
  input wire MCLK,
  input wire RESET,
  // ahb-lite slave
  input wire HSEL,
  input wire [31:0] HADDR,
  input wire [1:0] HTRANS,
  input wire HWRITE,
  input wire [2:0] HSIZE,
  input wire HREADY,
  input wire [31:0] HWDATA,
  output reg [31:0] HRDATA,
  output reg HREADYOUT,
  output reg HRESP,
  // data clock pin
  input wire DCLK_I,
  output reg DCLK_O,
  output reg DCLK_OE,
  output reg DCLK_DRIVE_24MA,
  // sample ports
  input wire [`DPF_SMP_W-1:0] PORT1_DATA,
  input wire [`DPF_SMP_W-1:0] PORT2_DATA,
  // modes set elsewhere in the device
  input wire EXT_PLL_LOCK,
  input wire SSB_MODE,
  // samples to the interpolation chain
  output reg [`DPF_SMP_W-1:0] SAMPLE_I,
  output reg [`DPF_SMP_W-1:0] SAMPLE_Q,
  output reg SAMPLE_VALID,
  // filter and routing controls
  output reg ROUTE_Q,
  output reg REAL_IMAG_SEL,
  output reg HILBERT_ON,
  output reg X8_HP,
  output reg X4_HP,
  output reg X2_HP,
  output reg LOOP_ACTIVE,
  // interrupt
  output reg IRQ
);

  ////////////////////////////////////////////////////////////////////////////
  // registers

  reg [7:0] data_if_reg;
  reg [7:0] filt_reg;
  reg [`DPF_EV_W-1:0] int_status_reg;
  reg [`DPF_EV_W-1:0] int_mask_reg;
  reg [7:0] data_if_next;
  reg [7:0] filt_next;
  reg [`DPF_EV_W-1:0] int_status_next;
  reg [`DPF_EV_W-1:0] int_mask_next;

  reg wr_pend_reg;
  reg [`DPF_IDX_W-1:0] wr_idx_reg;

  wire htrans_start;
  wire addr_phase;
  wire [`DPF_IDX_W-1:0] a_idx;
  wire rd_req;
  wire wr_req;
  wire rd_status;
  wire [7:0] wdata8;

  wire loop_locked;
  wire loop_slipped;
  wire loop_jitter;
  wire [`DPF_EV_W-1:0] loop_event;
  wire loop_en_eff;
  wire [7:0] data_if_view;
  wire irq_next;

  // only NONSEQ and SEQ open a transfer; IDLE and BUSY pass untouched
  assign htrans_start = (HTRANS == `DPF_HTRANS_NONSEQ) | (HTRANS == `DPF_HTRANS_SEQ);
  assign addr_phase = HSEL & HREADY & htrans_start;
  assign a_idx = HADDR[`DPF_IDX_W+`DPF_ADDR_LSB-1:`DPF_ADDR_LSB];
  assign rd_req = addr_phase & ~HWRITE;
  assign wr_req = addr_phase & HWRITE;
  assign rd_status = rd_req & (a_idx == `DPF_IDX_INT_STATUS);
  assign wdata8 = HWDATA[7:0];

  // next values of the writable registers; writes land in the data phase
  always @* begin
    data_if_next = data_if_reg;
    filt_next = filt_reg;
    int_mask_next = int_mask_reg;
    if (wr_pend_reg) begin
      case (wr_idx_reg)
        `DPF_IDX_DATA_IF: begin
          data_if_next = wdata8 & `DPF_DATA_IF_WMASK;
        end
        `DPF_IDX_FILT_MODE2: begin
          filt_next = wdata8 & `DPF_FILT_WMASK;
        end
        `DPF_IDX_INT_MASK: begin
          int_mask_next = wdata8[`DPF_EV_W-1:0];
        end
        default: begin
          data_if_next = data_if_reg;
        end
      endcase
    end
    // a read clears what it saw, but a fresh event still lands
    int_status_next = (int_status_reg & ~({`DPF_EV_W{rd_status}})) | loop_event;
  end

  // status bits come live from the monitor; a write never reaches them
  assign data_if_view = {data_if_next[7:3], loop_locked, loop_slipped, loop_jitter};
  // follows the values landing at this edge, so it never lags a clear
  assign irq_next = |(int_status_next & int_mask_next);

  always @(posedge MCLK or posedge RESET) begin
    if (RESET) begin
      data_if_reg <= `DPF_RESET_8; // R17
      filt_reg <= `DPF_RESET_8; // R17
      int_status_reg <= `DPF_RESET_EV;
      int_mask_reg <= `DPF_RESET_EV;
      wr_pend_reg <= 1'b0;
      wr_idx_reg <= {`DPF_IDX_W{1'b0}};
    end else begin
      data_if_reg <= data_if_next;
      filt_reg <= filt_next;
      int_status_reg <= int_status_next;
      int_mask_reg <= int_mask_next;
      wr_pend_reg <= wr_req;
      wr_idx_reg <= a_idx;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // bus answer: zero wait, always okay

  reg [31:0] rdata_mux;

  // read mux looks at next values of the writable registers so a read right behind a write sees it; status reads the register
  always @* begin
    rdata_mux = 32'h0000_0000;
    case (a_idx)
      `DPF_IDX_DATA_IF: begin
        rdata_mux[7:0] = data_if_view;
      end
      `DPF_IDX_FILT_MODE2: begin
        rdata_mux[7:0] = filt_next;
      end
      `DPF_IDX_INT_STATUS: begin
        rdata_mux[`DPF_EV_W-1:0] = int_status_reg;
      end
      `DPF_IDX_INT_MASK: begin
        rdata_mux[`DPF_EV_W-1:0] = int_mask_next;
      end
      default: begin
        rdata_mux = 32'h0000_0000;
      end
    endcase
  end

  always @(posedge MCLK or posedge RESET) begin
    if (RESET) begin
      HRDATA <= 32'h0000_0000;
      HREADYOUT <= 1'b1;
      HRESP <= `DPF_HRESP_OKAY;
      IRQ <= 1'b0;
    end else begin
      HREADYOUT <= 1'b1;
      HRESP <= `DPF_HRESP_OKAY;
      if (rd_req) begin
        HRDATA <= rdata_mux;
      end
      IRQ <= irq_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers: clock and data share the same delay

  wire [2*`DPF_SMP_W:0] pin_s;
  wire dclk_s;
  wire [`DPF_SMP_W-1:0] p1_s;
  wire [`DPF_SMP_W-1:0] p2_s;

  dpf_sync2 #(
    .W(2*`DPF_SMP_W+1)
  ) u_pin_sync (
    .clk(MCLK),
    .rst(RESET),
    .d({DCLK_I, PORT2_DATA, PORT1_DATA}),
    .q(pin_s)
  );

  assign dclk_s = pin_s[2*`DPF_SMP_W];
  assign p2_s = pin_s[2*`DPF_SMP_W-1:`DPF_SMP_W];
  assign p1_s = pin_s[`DPF_SMP_W-1:0];

  ////////////////////////////////////////////////////////////////////////////
  // data clock pin: driven out or taken in

  wire drive_out;
  reg [7:0] div_reg;
  reg dclk_in_d_reg;
  wire in_edge;
  wire out_edge;
  wire smp_edge;

  // limitation: when driving, the ports are taken as they stood two cycles
  // before our own rise, so the source must launch early in the low phase
  // with the external lock control on, the pin stays an input
  assign drive_out = data_if_reg[`DPF_B_DIR] & ~EXT_PLL_LOCK; // R06 R07
  assign in_edge = dclk_s & ~dclk_in_d_reg;
  assign out_edge = drive_out & ~DCLK_O & (div_reg == `DPF_DCLK_HALF_CYC - 8'h01);
  assign smp_edge = drive_out ? out_edge : in_edge;
  assign loop_en_eff = data_if_reg[`DPF_B_LOOP_EN] & ~drive_out; // R05

  always @(posedge MCLK or posedge RESET) begin
    if (RESET) begin
      div_reg <= 8'h00;
      DCLK_O <= 1'b0;
      DCLK_OE <= 1'b0;
      DCLK_DRIVE_24MA <= 1'b0;
      dclk_in_d_reg <= 1'b0;
      LOOP_ACTIVE <= 1'b0;
    end else begin
      dclk_in_d_reg <= dclk_s;
      DCLK_OE <= drive_out; // R07
      DCLK_DRIVE_24MA <= data_if_reg[`DPF_B_DRIVE]; // R04
      LOOP_ACTIVE <= loop_en_eff; // R05
      if (!drive_out) begin
        div_reg <= 8'h00;
        DCLK_O <= 1'b0;
      end else if (div_reg == `DPF_DCLK_HALF_CYC - 8'h01) begin
        div_reg <= 8'h00;
        DCLK_O <= ~DCLK_O; // R07
      end else begin
        div_reg <= div_reg + 8'h01;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // data clock loop monitor

  // own output edges say nothing about the far clock, so input edges only
  dpf_loop_mon u_loop (
    .clk(MCLK),
    .rst(RESET),
    .enable(loop_en_eff),
    .clk_edge(in_edge),
    .locked_reg(loop_locked),
    .slipped_reg(loop_slipped),
    .jitter_reg(loop_jitter),
    .event_reg(loop_event)
  );

  ////////////////////////////////////////////////////////////////////////////
  // sample capture

  reg phase_q_reg;
  reg [`DPF_SMP_W-1:0] hold_i_reg;
  wire [`DPF_SMP_W-1:0] fmt1;
  wire [`DPF_SMP_W-1:0] fmt2;

  // dual port: both words of a pair are taken at the one edge
  // unsigned input becomes two's complement by flipping the msb
  assign fmt1 = data_if_reg[`DPF_B_FORMAT] ?
    {~p1_s[`DPF_SMP_W-1], p1_s[`DPF_SMP_W-2:0]} : p1_s; // R01 R02
  assign fmt2 = data_if_reg[`DPF_B_FORMAT] ?
    {~p2_s[`DPF_SMP_W-1], p2_s[`DPF_SMP_W-2:0]} : p2_s; // R01 R02

  always @(posedge MCLK or posedge RESET) begin
    if (RESET) begin
      phase_q_reg <= 1'b0;
      hold_i_reg <= {`DPF_SMP_W{1'b0}};
      SAMPLE_I <= {`DPF_SMP_W{1'b0}};
      SAMPLE_Q <= {`DPF_SMP_W{1'b0}};
      SAMPLE_VALID <= 1'b0;
    end else begin
      SAMPLE_VALID <= 1'b0;
      if (!data_if_reg[`DPF_B_SINGLE_PORT_INTERLEAVE]) begin
        phase_q_reg <= 1'b0;
        if (smp_edge) begin
          SAMPLE_I <= fmt1; // R03
          SAMPLE_Q <= fmt2; // R03
          SAMPLE_VALID <= 1'b1;
        end
      end else if (smp_edge) begin
        // interleaved: I first, the pair leaves with its Q word
        phase_q_reg <= ~phase_q_reg;
        if (!phase_q_reg) begin
          hold_i_reg <= fmt1; // R03
        end else begin
          SAMPLE_I <= hold_i_reg; // R03
          SAMPLE_Q <= fmt1;
          SAMPLE_VALID <= 1'b1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // filter and routing controls

  always @(posedge MCLK or posedge RESET) begin
    if (RESET) begin
      ROUTE_Q <= 1'b0;
      REAL_IMAG_SEL <= 1'b0;
      HILBERT_ON <= 1'b0;
      X8_HP <= 1'b0;
      X4_HP <= 1'b0;
      X2_HP <= 1'b0;
    end else begin
      // channel select only without sideband mode, the other two only with it
      ROUTE_Q <= ~SSB_MODE & filt_reg[`DPF_B_CHANNEL]; // R12
      REAL_IMAG_SEL <= SSB_MODE & filt_reg[`DPF_B_REAL_OR_IMAG_SELECT]; // R13
      HILBERT_ON <= SSB_MODE & filt_reg[`DPF_B_HILBERT]; // R14
      X8_HP <= filt_reg[`DPF_B_X8HP]; // R15
      X4_HP <= filt_reg[`DPF_B_X4HP]; // R15
      X2_HP <= filt_reg[`DPF_B_X2HP]; // R16
    end
  end

endmodule

/* tb/dpf_asserts.sv */
`timescale 1ns/1ps
module dpf_asserts (
  // clock and reset
  input wire MCLK,
  input wire RESET,
  // bus
  input wire HSEL,
  input wire [31:0] HADDR,
  input wire [1:0] HTRANS,
  input wire HWRITE,
  input wire HREADY,
  input wire [31:0] HWDATA,
  // pin and controls
  input wire DCLK_O,
  input wire DCLK_OE,
  input wire DCLK_DRIVE_24MA,
  input wire EXT_PLL_LOCK,
  input wire SAMPLE_VALID,
  input wire ROUTE_Q,
  input wire X8_HP,
  input wire X4_HP,
  input wire X2_HP,
  input wire LOOP_ACTIVE
);
  logic wr_seen_reg;
  logic [7:0] idx_seen_reg;

  // remembers the address phase so the data phase can be matched
  always @(posedge MCLK or posedge RESET) begin
    if (RESET) begin
      wr_seen_reg <= 1'b0;
      idx_seen_reg <= 8'h00;
    end else if (HREADY) begin
      wr_seen_reg <= HSEL && HTRANS[1] && HWRITE;
      idx_seen_reg <= HADDR[9:2];
    end
  end

  default clocking cb @(posedge MCLK);
  endclocking
  default disable iff (RESET);

  a_reset_zero: assert property (
    $fell(RESET) |-> !ROUTE_Q && !X8_HP && !DCLK_OE && !LOOP_ACTIVE)
    else $error("control output set after reset");
  a_pll_input: assert property (EXT_PLL_LOCK |=> !DCLK_OE)
    else $error("pin driven with external lock on");
  a_pin_idle_low: assert property (!DCLK_OE && !$past(DCLK_OE) |-> !DCLK_O)
    else $error("clock out not low while idle");
  a_dclk_half: assert property (
    $fell(DCLK_O) && DCLK_OE |-> ##4 (DCLK_O || !DCLK_OE))
    else $error("clock out half period wrong");
  a_valid_pulse: assert property (SAMPLE_VALID |=> !SAMPLE_VALID)
    else $error("sample valid longer than one cycle");
  a_drive_write: assert property (
    wr_seen_reg && idx_seen_reg == 8'h02 |-> ##2 DCLK_DRIVE_24MA == $past(HWDATA[5], 2))
    else $error("drive select does not follow write");
  a_filt_write: assert property (
    wr_seen_reg && idx_seen_reg == 8'h03 |-> ##2 {X8_HP, X4_HP, X2_HP} == $past(HWDATA[4:2], 2))
    else $error("stage response does not follow write");
  a_loop_input: assert property (!(LOOP_ACTIVE && DCLK_OE))
    else $error("loop active while pin driven");
endmodule

bind dpf_top dpf_asserts u_dpf_asserts (
  .MCLK(MCLK), .RESET(RESET), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS),
  .HWRITE(HWRITE), .HREADY(HREADY), .HWDATA(HWDATA), .DCLK_O(DCLK_O),
  .DCLK_OE(DCLK_OE), .DCLK_DRIVE_24MA(DCLK_DRIVE_24MA), .EXT_PLL_LOCK(EXT_PLL_LOCK),
  .SAMPLE_VALID(SAMPLE_VALID), .ROUTE_Q(ROUTE_Q), .X8_HP(X8_HP), .X4_HP(X4_HP),
  .X2_HP(X2_HP), .LOOP_ACTIVE(LOOP_ACTIVE));

/* tb/dpf_source.sv */
`timescale 1ns/1ps
module dpf_source (
  // control
  input wire run,
  input wire [7:0] stretch_ns,
  // data clock pin as seen on the board
  input wire pin,
  output logic clk_out,
  // sample ports
  output logic [11:0] port1,
  output logic [11:0] port2
);
  initial begin
    clk_out = 1'b0;
    port1 = 12'h5A3;
    port2 = 12'hA5C;
  end

  // 400 ns period, off the mclk grid; stands low while stopped
  always begin
    wait (run);
    #13 clk_out = 1'b1;
    #200 clk_out = 1'b0;
    #(187 + stretch_ns);
  end

  // new words early in the low phase: a driving device samples the ports
  // two of its cycles ahead of its own rise
  always @(negedge pin) begin
    #40;
    port1 = port1 + 12'h1B7;
    port2 = port2 - 12'h2C5;
  end
endmodule

/* tb/dpf_top_tb_top.sv */
`timescale 1ns/1ps
module dpf_top_tb_top;
  logic mclk, reset, hsel, hwrite, ext_pll, ssb, run, src_clk, fmt_uns, one_port, mon_on;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic hrdy, hresp, dclk_o, dclk_oe, drv24, s_valid, irq, rte_q, re_im, hilb, x8, x4, x2, lp_act;
  logic [11:0] s_i, s_q, p1, p2, p1_now, p1_old, p2_now;
  logic [7:0] stretch;
  int mismatches = 0;
  int n_tests = 0;
  int n;
  wire dclk_pin = dclk_oe ? dclk_o : src_clk;

  dpf_top u_dpf_top (.MCLK(mclk), .RESET(reset), .HSEL(hsel), .HADDR(haddr),
    .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(hsize), .HREADY(hrdy), .HWDATA(hwdata),
    .HRDATA(hrdata), .HREADYOUT(hrdy), .HRESP(hresp), .DCLK_I(dclk_pin), .DCLK_O(dclk_o),
    .DCLK_OE(dclk_oe), .DCLK_DRIVE_24MA(drv24), .PORT1_DATA(p1), .PORT2_DATA(p2),
    .EXT_PLL_LOCK(ext_pll), .SSB_MODE(ssb), .SAMPLE_I(s_i), .SAMPLE_Q(s_q),
    .SAMPLE_VALID(s_valid), .ROUTE_Q(rte_q), .REAL_IMAG_SEL(re_im), .HILBERT_ON(hilb),
    .X8_HP(x8), .X4_HP(x4), .X2_HP(x2), .LOOP_ACTIVE(lp_act), .IRQ(irq));
  dpf_source u_dpf_source (.run(run), .stretch_ns(stretch), .pin(dclk_pin),
    .clk_out(src_clk), .port1(p1), .port2(p2));

  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  task automatic complete_run;
    $display("checks %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic edge_rdy;
    int k;
    k = 0;
    do begin
      @(posedge mclk);
      k++;
    end while (hrdy !== 1'b1 && k < 40);
    if (k >= 40) begin
      mismatches++;
      complete_run();
    end
  endtask

  task automatic xfer(input logic w, input logic [7:0] idx, input logic [31:0] wd);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {22'h0, idx, 2'h0};
    edge_rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    edge_rdy();
    rd = hrdata;
  endtask

  // mode change with the sample check paused while the pipeline refills
  task automatic stream(input logic [7:0] v);
    mon_on <= 1'b0;
    xfer(1, 8'h02, 32'(v));
    fmt_uns <= v[7];
    one_port <= v[6];
    repeat (24) @(posedge mclk);
    mon_on <= 1'b1;
    repeat (48) @(posedge mclk);
  endtask

  task automatic bump(input logic [7:0] v);
    stretch <= v;
    repeat (12) @(posedge mclk);
    stretch <= 8'h00;
    repeat (40) @(posedge mclk);
    xfer(0, 8'h02, 0);
  endtask

  function automatic logic [31:0] fix(input logic [11:0] x);
    return fmt_uns ? {20'h0, ~x[11], x[10:0]} : {20'h0, x};
  endfunction

  always @(posedge dclk_pin) begin
    p1_old <= p1_now;
    p1_now <= p1;
    p2_now <= p2;
  end

  always @(posedge mclk) begin
    if (mon_on && s_valid === 1'b1) begin
      chk("sample i", fix(one_port ? p1_old : p1_now), 32'(s_i));
      chk("sample q", fix(one_port ? p1_now : p2_now), 32'(s_q));
    end
  end

  initial begin
    reset = 1'b1;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    ext_pll = 1'b0;
    ssb = 1'b0;
    run = 1'b0;
    stretch = 8'h00;
    fmt_uns = 1'b0;
    one_port = 1'b0;
    mon_on = 1'b0;
    repeat (2) @(posedge mclk);
    reset <= 1'b0;
    @(posedge mclk);
    xfer(1, 8'h06, 32'hFF);
    for (int i = 2; i < 7; i++) begin
      xfer(0, 8'(i), 0);
      chk("reset reg", 0, rd);
    end
    chk("reset outs", 0, 32'({rte_q, x8, dclk_oe, lp_act, irq, hresp}));
    for (int b = 2; b < 8; b++) begin
      ssb <= (b == 5 || b == 6);
      xfer(1, 8'h03, 32'h1 << b);
      xfer(0, 8'h03, 0);
      chk("filt reg", 32'h1 << b, rd);
      // controls settle one edge behind the register
      @(posedge mclk);
      chk("filt out", 32'h1 << b, 32'({rte_q, re_im, hilb, x8, x4, x2, 2'h0}));
    end
    xfer(1, 8'h03, 32'hFF);
    xfer(0, 8'h03, 0);
    chk("filt low bits", 32'hFC, rd);
    xfer(1, 8'h02, 32'h2F);
    xfer(0, 8'h02, 0);
    chk("dif reg", 32'h28, rd);
    @(posedge mclk);
    chk("pin out", 32'h3, 32'({dclk_oe, drv24}));
    stream(8'h28);
    stream(8'hA8);
    stream(8'h68);
    stream(8'hE8);
    ext_pll <= 1'b1;
    repeat (2) @(posedge mclk);
    chk("pll forces input", 0, 32'(dclk_oe));
    ext_pll <= 1'b0;
    run <= 1'b1;
    stream(8'h00);
    xfer(1, 8'h05, 32'h7);
    xfer(1, 8'h02, 32'h10);
    xfer(0, 8'h02, 0);
    chk("not locked", 32'h10, rd);
    @(posedge mclk);
    chk("loop active", 1, 32'(lp_act));
    n = 0;
    do begin
      xfer(0, 8'h02, 0);
      n++;
    end while (rd[2] !== 1'b1 && n < 60);
    chk("locked", 32'h14, rd);
    if (rd[2] !== 1'b1) complete_run();
    chk("irq lock", 1, 32'(irq));
    xfer(0, 8'h04, 0);
    chk("lock event", 1, rd);
    xfer(1, 8'h05, 32'h3);
    bump(8'd50);
    chk("jitter", 32'h15, rd);
    chk("irq masked", 0, 32'(irq));
    xfer(0, 8'h04, 0);
    chk("jitter event", 32'h4, rd);
    xfer(1, 8'h05, 32'h7);
    bump(8'd150);
    chk("slip", 32'h17, rd);
    chk("irq slip", 1, 32'(irq));
    xfer(0, 8'h04, 0);
    chk("slip event", 32'h2, rd);
    xfer(1, 8'h02, 0);
    xfer(0, 8'h02, 0);
    chk("sticky status", 32'h7, rd);
    run <= 1'b0;
    reset <= 1'b1;
    repeat (2) @(posedge mclk);
    reset <= 1'b0;
    @(posedge mclk);
    xfer(0, 8'h02, 0);
    chk("second reset", 0, rd);
    complete_run();
  end
endmodule
